// ===== hw/afc_frontend_regs.vh
/*
  Constants for the analog front-end control register bank: register
  addresses, field positions, write masks, reset values and decode codes.
  Assumes it is included by bare name from every design file of the block.
*/
`ifndef AFC_FRONTEND_REGS_VH
`define AFC_FRONTEND_REGS_VH

// register addresses
`define AFC_ADDR_AMP1_CONTROL 8'h00
`define AFC_ADDR_AMP2_CONTROL 8'h01
`define AFC_ADDR_BANDGAP_CONTROL 8'h02
`define AFC_ADDR_BANDGAP_TRIM 8'h03
`define AFC_ADDR_AMP1_GAIN 8'h04
`define AFC_ADDR_STATUS 8'h05

// reset values and write masks
`define AFC_RESET_VALUE 8'h00
`define AFC_READ_ZERO 8'h00
`define AFC_AMP_WMASK 8'hFF
`define AFC_BANDGAP_WMASK 8'h13
`define AFC_TRIM_WMASK 8'hFF
`define AFC_GAIN_WMASK 8'h03

// amplifier control fields
`define AFC_AMP_MODE_BIT 7
`define AFC_AMP_REF_BIT 6
`define AFC_AMP_EN_BIT 5
`define AFC_AMP_TRIM_HI 4
`define AFC_AMP_TRIM_LO 0

// bandgap control fields
`define AFC_BG_EN_BIT 4
`define AFC_BG_SEL_HI 1
`define AFC_BG_SEL_LO 0
`define AFC_BG_SEL_SUPPLY 2'h2
`define AFC_BG_SEL_FLOAT 2'h3

// gain select field and codes
`define AFC_GAIN_HI 1
`define AFC_GAIN_LO 0
`define AFC_GAIN_LOW 2'h0
`define AFC_GAIN_MID 2'h1
`define AFC_GAIN_HIGH 2'h2

// one-hot gain switch closes, one per gain code
`define AFC_SW_GAIN_LOW 3'h1
`define AFC_SW_GAIN_MID 3'h2
`define AFC_SW_GAIN_HIGH 3'h4

// converter channels fed by the amplifiers
`define AFC_CH_AMP1_FIRST 3'h4
`define AFC_CH_AMP1_LAST 3'h6
`define AFC_CH_AMP2 3'h7

// status register bit positions
`define AFC_ST_AMP1_ROUTE 0
`define AFC_ST_AMP2_ROUTE 1
`define AFC_ST_AMP1_CANCEL 2
`define AFC_ST_AMP2_CANCEL 3
`define AFC_ST_BG_DOWN 4
`define AFC_ST_BG_FLOAT 5

`endif

// ===== hw/afc_ctl_reg.v
/*
  One software register with a per-bit write mask; unmasked bits stay at
  reset value and so read as zero. Exposes its next value so that decoded
  outputs can update on the same edge as the register itself.
  Assumes a synchronous active-low reset and writes qualified by the top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afc_frontend_regs.vh"

module afc_ctl_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] WMASK = `AFC_AMP_WMASK,
  parameter [WIDTH-1:0] RESET = `AFC_RESET_VALUE
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire wr_en_i,
  input wire [WIDTH-1:0] wdata_i,
  output reg [WIDTH-1:0] q_o,
  output reg [WIDTH-1:0] next_q_o
);

  // merge written bits under the mask, keep the rest
  always @* begin
    next_q_o = q_o;
    if (wr_en_i) begin
      next_q_o = (wdata_i & WMASK) | (q_o & ~WMASK);
    end
  end

  // storage, loaded on the write cycle's edge
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      q_o <= RESET;
    end else begin
      q_o <= next_q_o;
    end
  end

endmodule
`default_nettype wire

// ===== hw/afc_amp_path.v
/*
  Control decode for one amplifier: enable, cancellation switches, trim
  code and converter routing, all registered from the next control value.
  Assumes the converter channel select is synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afc_frontend_regs.vh"

module afc_amp_path #(
  parameter [2:0] CH_FIRST = `AFC_CH_AMP1_FIRST,
  parameter [2:0] CH_LAST = `AFC_CH_AMP1_LAST
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] next_ctl_i,
  input wire [2:0] adc_channel_i,
  output reg enable_o,
  output reg cancel_mode_o,
  output reg cancel_switch_a_o,
  output reg cancel_switch_b_o,
  output reg [4:0] offset_trim_o,
  output reg route_o
);

  wire next_mode;
  wire next_ref;
  wire next_en;
  wire chan_hit;

  assign next_mode = next_ctl_i[`AFC_AMP_MODE_BIT];
  assign next_ref = next_ctl_i[`AFC_AMP_REF_BIT];
  assign next_en = next_ctl_i[`AFC_AMP_EN_BIT];
  assign chan_hit = (adc_channel_i >= CH_FIRST) && (adc_channel_i <= CH_LAST);

  // switch a ties the negative input, switch b the positive input
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      enable_o <= 1'b0;
      cancel_mode_o <= 1'b0;
      // cleared mode bit means normal mode, so both switches stay closed
      cancel_switch_a_o <= 1'b1;
      cancel_switch_b_o <= 1'b1;
      offset_trim_o <= 5'h00;
      route_o <= 1'b0;
    end else begin
      enable_o <= next_en;
      cancel_mode_o <= next_mode;
      cancel_switch_a_o <= !next_mode || !next_ref;
      cancel_switch_b_o <= !next_mode || next_ref;
      offset_trim_o <= next_ctl_i[`AFC_AMP_TRIM_HI:`AFC_AMP_TRIM_LO];
      route_o <= next_en && chan_hit;
    end
  end

endmodule
`default_nettype wire

// ===== hw/afc_frontend_regs.v
/*
  Register bank for the analog front end: two amplifier control registers,
  bandgap control and trim, a gain select and a read-only status word.
  Drives every analog control line from flip-flops.
  Assumes a plain register port: one-cycle strobes, never both at once,
  read data valid only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afc_frontend_regs.vh"

module afc_frontend_regs #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [ADDR_WIDTH-1:0] reg_addr_i,
  input wire [DATA_WIDTH-1:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [DATA_WIDTH-1:0] reg_rdata_o,
  input wire [2:0] adc_channel_i,
  output wire amp1_enable_o,
  output wire amp1_mode_select_o,
  output wire amp1_cancel_ref_select_o,
  output wire cancel_switch_a_o,
  output wire cancel_switch_b_o,
  output wire [4:0] amp1_offset_trim_o,
  output reg [2:0] amp1_gain_switches_o,
  output wire amp1_route_o,
  output wire amp2_enable_o,
  output wire amp2_mode_select_o,
  output wire amp2_cancel_ref_select_o,
  output wire amp2_cancel_switch_a_o,
  output wire amp2_cancel_switch_b_o,
  output wire [4:0] amp2_offset_trim_o,
  output wire amp2_route_o,
  output reg bandgap_enable_o,
  output reg bandgap_power_down_o,
  output reg [1:0] bandgap_output_select_o,
  output reg bandgap_ref_fixed_o,
  output reg bandgap_ref_supply_o,
  output reg bandgap_ref_float_o,
  output wire [7:0] bandgap_trim_code_o
);

  // register contents and their next values
  wire [7:0] amp1_control;
  wire [7:0] amp2_control;
  wire [7:0] bandgap_control;
  wire [7:0] bandgap_trim_code;
  wire [7:0] amp1_gain_select;
  wire [7:0] next_amp1_control;
  wire [7:0] next_amp2_control;
  wire [7:0] next_bandgap_control;
  wire [7:0] next_bandgap_trim_code;
  wire [7:0] next_amp1_gain_select;

  // address decode results
  wire sel_amp1;
  wire sel_amp2;
  wire sel_bg;
  wire sel_trim;
  wire sel_gain;
  wire sel_status;
  wire wr_amp1;
  wire wr_amp2;
  wire wr_bg;
  wire wr_trim;
  wire wr_gain;

  // decoded amplifier status from the path modules
  wire amp1_cancel_mode;
  wire amp2_cancel_mode;

  // bandgap and gain decode inputs
  wire next_bg_en;
  wire [1:0] next_bg_sel;
  wire [1:0] next_gain;

  // read path
  reg [7:0] next_rdata;
  wire [7:0] status_word;

  // address comparison over the full address width against the 8-bit addresses
  assign sel_amp1 = (reg_addr_i == `AFC_ADDR_AMP1_CONTROL);
  assign sel_amp2 = (reg_addr_i == `AFC_ADDR_AMP2_CONTROL);
  assign sel_bg = (reg_addr_i == `AFC_ADDR_BANDGAP_CONTROL);
  assign sel_trim = (reg_addr_i == `AFC_ADDR_BANDGAP_TRIM);
  assign sel_gain = (reg_addr_i == `AFC_ADDR_AMP1_GAIN);
  assign sel_status = (reg_addr_i == `AFC_ADDR_STATUS);

  // write qualification; status and unmapped addresses drop writes
  assign wr_amp1 = reg_write_i && sel_amp1;
  assign wr_amp2 = reg_write_i && sel_amp2;
  assign wr_bg = reg_write_i && sel_bg;
  assign wr_trim = reg_write_i && sel_trim;
  assign wr_gain = reg_write_i && sel_gain;

  // first amplifier control, all eight bits writable
  afc_ctl_reg #(
    .WIDTH(8),
    .WMASK(`AFC_AMP_WMASK),
    .RESET(`AFC_RESET_VALUE)
  ) u_amp1_control (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_amp1),
    .wdata_i(reg_wdata_i[7:0]),
    .q_o(amp1_control),
    .next_q_o(next_amp1_control)
  );

  // second amplifier control, same layout as the first
  afc_ctl_reg #(
    .WIDTH(8),
    .WMASK(`AFC_AMP_WMASK),
    .RESET(`AFC_RESET_VALUE)
  ) u_amp2_control (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_amp2),
    .wdata_i(reg_wdata_i[7:0]),
    .q_o(amp2_control),
    .next_q_o(next_amp2_control)
  );

  // bandgap control, only enable and output select implemented
  afc_ctl_reg #(
    .WIDTH(8),
    .WMASK(`AFC_BANDGAP_WMASK),
    .RESET(`AFC_RESET_VALUE)
  ) u_bandgap_control (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_bg),
    .wdata_i(reg_wdata_i[7:0]),
    .q_o(bandgap_control),
    .next_q_o(next_bandgap_control)
  );

  // bandgap fine-trim code
  afc_ctl_reg #(
    .WIDTH(8),
    .WMASK(`AFC_TRIM_WMASK),
    .RESET(`AFC_RESET_VALUE)
  ) u_bandgap_trim (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_trim),
    .wdata_i(reg_wdata_i[7:0]),
    .q_o(bandgap_trim_code),
    .next_q_o(next_bandgap_trim_code)
  );

  // first amplifier gain select, two bits
  afc_ctl_reg #(
    .WIDTH(8),
    .WMASK(`AFC_GAIN_WMASK),
    .RESET(`AFC_RESET_VALUE)
  ) u_amp1_gain (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_gain),
    .wdata_i(reg_wdata_i[7:0]),
    .q_o(amp1_gain_select),
    .next_q_o(next_amp1_gain_select)
  );

  // first amplifier path, feeds converter channels four to six
  afc_amp_path #(
    .CH_FIRST(`AFC_CH_AMP1_FIRST),
    .CH_LAST(`AFC_CH_AMP1_LAST)
  ) u_amp1_path (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .next_ctl_i(next_amp1_control),
    .adc_channel_i(adc_channel_i),
    .enable_o(amp1_enable_o),
    .cancel_mode_o(amp1_cancel_mode),
    .cancel_switch_a_o(cancel_switch_a_o),
    .cancel_switch_b_o(cancel_switch_b_o),
    .offset_trim_o(amp1_offset_trim_o),
    .route_o(amp1_route_o)
  );

  // second amplifier path, feeds converter channel seven only
  afc_amp_path #(
    .CH_FIRST(`AFC_CH_AMP2),
    .CH_LAST(`AFC_CH_AMP2)
  ) u_amp2_path (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .next_ctl_i(next_amp2_control),
    .adc_channel_i(adc_channel_i),
    .enable_o(amp2_enable_o),
    .cancel_mode_o(amp2_cancel_mode),
    .cancel_switch_a_o(amp2_cancel_switch_a_o),
    .cancel_switch_b_o(amp2_cancel_switch_b_o),
    .offset_trim_o(amp2_offset_trim_o),
    .route_o(amp2_route_o)
  );

  // raw mode and reference bits straight from the stored registers
  assign amp1_mode_select_o = amp1_control[`AFC_AMP_MODE_BIT];
  assign amp1_cancel_ref_select_o = amp1_control[`AFC_AMP_REF_BIT];
  assign amp2_mode_select_o = amp2_control[`AFC_AMP_MODE_BIT];
  assign amp2_cancel_ref_select_o = amp2_control[`AFC_AMP_REF_BIT];

  // trim code goes to the bandgap DAC unchanged
  assign bandgap_trim_code_o = bandgap_trim_code;

  // next-value fields that steer the registered decodes
  assign next_bg_en = next_bandgap_control[`AFC_BG_EN_BIT];
  assign next_bg_sel = next_bandgap_control[`AFC_BG_SEL_HI:`AFC_BG_SEL_LO];
  assign next_gain = next_amp1_gain_select[`AFC_GAIN_HI:`AFC_GAIN_LO];

  // gain switches: exactly one closed; unused code 3 falls to lowest gain
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      amp1_gain_switches_o <= `AFC_SW_GAIN_LOW;
    end else begin
      case (next_gain)
        `AFC_GAIN_LOW: begin
          amp1_gain_switches_o <= `AFC_SW_GAIN_LOW;
        end
        `AFC_GAIN_MID: begin
          amp1_gain_switches_o <= `AFC_SW_GAIN_MID;
        end
        `AFC_GAIN_HIGH: begin
          amp1_gain_switches_o <= `AFC_SW_GAIN_HIGH;
        end
        default: begin
          amp1_gain_switches_o <= `AFC_SW_GAIN_LOW;
        end
      endcase
    end
  end

  // bandgap enable and power-down, always complementary
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      bandgap_enable_o <= 1'b0;
      bandgap_power_down_o <= 1'b1;
    end else begin
      bandgap_enable_o <= next_bg_en;
      bandgap_power_down_o <= !next_bg_en;
    end
  end

  // bandgap reference selection, one-hot towards the analog mux
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      bandgap_output_select_o <= 2'h0;
      bandgap_ref_fixed_o <= 1'b1;
      bandgap_ref_supply_o <= 1'b0;
      bandgap_ref_float_o <= 1'b0;
    end else begin
      bandgap_output_select_o <= next_bg_sel;
      case (next_bg_sel)
        `AFC_BG_SEL_SUPPLY: begin
          bandgap_ref_fixed_o <= 1'b0;
          bandgap_ref_supply_o <= 1'b1;
          bandgap_ref_float_o <= 1'b0;
        end
        `AFC_BG_SEL_FLOAT: begin
          bandgap_ref_fixed_o <= 1'b0;
          bandgap_ref_supply_o <= 1'b0;
          bandgap_ref_float_o <= 1'b1;
        end
        default: begin
          bandgap_ref_fixed_o <= 1'b1;
          bandgap_ref_supply_o <= 1'b0;
          bandgap_ref_float_o <= 1'b0;
        end
      endcase
    end
  end

  // read-only status built from registered outputs
  assign status_word = {
    2'h0,
    bandgap_ref_float_o,
    bandgap_power_down_o,
    amp2_cancel_mode,
    amp1_cancel_mode,
    amp2_route_o,
    amp1_route_o
  };

  // read multiplexer; unmapped addresses answer zero
  always @* begin
    next_rdata = `AFC_READ_ZERO;
    if (reg_read_i) begin
      case (reg_addr_i)
        `AFC_ADDR_AMP1_CONTROL: begin
          next_rdata = amp1_control;
        end
        `AFC_ADDR_AMP2_CONTROL: begin
          next_rdata = amp2_control;
        end
        `AFC_ADDR_BANDGAP_CONTROL: begin
          next_rdata = bandgap_control & `AFC_BANDGAP_WMASK;
        end
        `AFC_ADDR_BANDGAP_TRIM: begin
          next_rdata = bandgap_trim_code;
        end
        `AFC_ADDR_AMP1_GAIN: begin
          next_rdata = amp1_gain_select & `AFC_GAIN_WMASK;
        end
        `AFC_ADDR_STATUS: begin
          next_rdata = status_word;
        end
        default: begin
          next_rdata = `AFC_READ_ZERO;
        end
      endcase
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= {DATA_WIDTH{1'b0}};
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== dv/afc_frontend_regs_properties.sv
/*
  Concurrent checks on the front-end register bank ports.
  Assumes one clock, synchronous active-low reset; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module afc_chk #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [ADDR_WIDTH-1:0] reg_addr_i,
  input wire [DATA_WIDTH-1:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [DATA_WIDTH-1:0] reg_rdata_o,
  input wire [2:0] adc_channel_i,
  input wire amp1_enable_o,
  input wire amp1_mode_select_o,
  input wire amp1_cancel_ref_select_o,
  input wire cancel_switch_a_o,
  input wire cancel_switch_b_o,
  input wire [4:0] amp1_offset_trim_o,
  input wire amp1_route_o,
  input wire amp2_enable_o,
  input wire amp2_mode_select_o,
  input wire amp2_route_o,
  input wire bandgap_power_down_o,
  input wire [1:0] bandgap_output_select_o,
  input wire bandgap_ref_fixed_o,
  input wire bandgap_ref_supply_o,
  input wire bandgap_ref_float_o,
  input wire [7:0] bandgap_trim_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // write strobes for registers 0x00 to 0x03; the gain register has none
  wire w0 = reg_write_i && reg_addr_i == 8'h00;
  wire w1 = reg_write_i && reg_addr_i == 8'h01;
  wire w2 = reg_write_i && reg_addr_i == 8'h02;
  wire w3 = reg_write_i && reg_addr_i == 8'h03;
  chk_amp1_mode: assert property (
    w0 |=> amp1_mode_select_o == $past(reg_wdata_i[7])) else $error("amp1 mode wrong");
  chk_amp1_ref: assert property (
    w0 |=> amp1_cancel_ref_select_o == $past(reg_wdata_i[6])) else $error("amp1 ref wrong");
  chk_normal_switches: assert property (
    $past(rst_b_i) && !amp1_mode_select_o |-> cancel_switch_a_o && cancel_switch_b_o)
    else $error("switches open in normal mode");
  chk_amp1_fields: assert property (
    w0 |=> {amp1_enable_o, amp1_offset_trim_o} == $past(reg_wdata_i[5:0]))
    else $error("amp1 enable or trim wrong");
  chk_amp2_fields: assert property (
    w1 |=> {amp2_mode_select_o, amp2_enable_o} == {$past(reg_wdata_i[7]), $past(reg_wdata_i[5])})
    else $error("amp2 mode or enable wrong");
  chk_amp1_route: assert property (
    $past(rst_b_i) |-> amp1_route_o == (amp1_enable_o && $past(adc_channel_i) >= 3'h4
    && $past(adc_channel_i) <= 3'h6)) else $error("amp1 route wrong");
  chk_amp2_route: assert property (
    $past(rst_b_i) |-> amp2_route_o == (amp2_enable_o && $past(adc_channel_i) == 3'h7))
    else $error("amp2 route wrong");
  chk_bandgap_down: assert property (
    w2 |=> bandgap_power_down_o == !$past(reg_wdata_i[4])) else $error("power down wrong");
  chk_ref_decode: assert property (
    w2 |=> bandgap_output_select_o == $past(reg_wdata_i[1:0]) && {bandgap_ref_float_o,
    bandgap_ref_supply_o, bandgap_ref_fixed_o} == {bandgap_output_select_o == 2'h3,
    bandgap_output_select_o == 2'h2, !bandgap_output_select_o[1]}) else $error("select wrong");
  chk_trim_code: assert property (
    w3 |=> bandgap_trim_code_o == $past(reg_wdata_i)) else $error("trim code wrong");
  chk_reserved_zero: assert property (
    reg_read_i && reg_addr_i == 8'h02 |=> (reg_rdata_o & 8'hec) == 8'h00)
    else $error("reserved bits not zero");
  chk_read_back: assert property (
    w3 ##1 reg_read_i && reg_addr_i == 8'h03 |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("read back wrong");
endmodule

bind afc_frontend_regs afc_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) chk_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .adc_channel_i(adc_channel_i), .amp1_enable_o(amp1_enable_o),
  .amp1_mode_select_o(amp1_mode_select_o), .amp1_cancel_ref_select_o(amp1_cancel_ref_select_o),
  .cancel_switch_a_o(cancel_switch_a_o), .cancel_switch_b_o(cancel_switch_b_o),
  .amp1_offset_trim_o(amp1_offset_trim_o), .amp1_route_o(amp1_route_o),
  .amp2_enable_o(amp2_enable_o), .amp2_mode_select_o(amp2_mode_select_o),
  .amp2_route_o(amp2_route_o), .bandgap_power_down_o(bandgap_power_down_o),
  .bandgap_output_select_o(bandgap_output_select_o), .bandgap_ref_fixed_o(bandgap_ref_fixed_o),
  .bandgap_ref_supply_o(bandgap_ref_supply_o), .bandgap_ref_float_o(bandgap_ref_float_o),
  .bandgap_trim_code_o(bandgap_trim_code_o)
);
`default_nettype wire

// ===== dv/afc_testbench.sv
/*
  Self-checking bench for the front-end register bank.
  Assumes the bank at addresses 0x00..0x05 with one-cycle read latency.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] adc_channel_i = 3'h0;
  wire [7:0] reg_rdata_o;
  wire [13:0] amp1;
  wire [10:0] amp2;
  wire [14:0] bg;
  logic [7:0] m [0:4];
  logic [31:0] rnd;
  integer num_errors = 0;
  integer compares = 0;
  integer seed = 32'h0000_c405;
  integer i;
  integer k;
  // expected routing from the model and the held channel
  wire r1 = m[0][5] && adc_channel_i >= 3'h4 && adc_channel_i <= 3'h6;
  wire r2 = m[1][5] && adc_channel_i == 3'h7;

  // clock
  always #10 clk_i = ~clk_i;

  afc_frontend_regs dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .adc_channel_i(adc_channel_i), .amp1_enable_o(amp1[13]), .amp1_mode_select_o(amp1[12]),
    .amp1_cancel_ref_select_o(amp1[11]), .cancel_switch_a_o(amp1[10]),
    .cancel_switch_b_o(amp1[9]), .amp1_offset_trim_o(amp1[8:4]),
    .amp1_gain_switches_o(amp1[3:1]), .amp1_route_o(amp1[0]), .amp2_enable_o(amp2[10]),
    .amp2_mode_select_o(amp2[9]), .amp2_cancel_ref_select_o(amp2[8]),
    .amp2_cancel_switch_a_o(amp2[7]), .amp2_cancel_switch_b_o(amp2[6]),
    .amp2_offset_trim_o(amp2[5:1]), .amp2_route_o(amp2[0]), .bandgap_enable_o(bg[14]),
    .bandgap_power_down_o(bg[13]), .bandgap_output_select_o(bg[12:11]),
    .bandgap_ref_fixed_o(bg[10]), .bandgap_ref_supply_o(bg[9]), .bandgap_ref_float_o(bg[8]),
    .bandgap_trim_code_o(bg[7:0])
  );

  // expected decode of one amplifier control byte
  function [9:0] ampx(input [7:0] c);
    ampx = {c[5], c[7], c[6], !c[7] | !c[6], !c[7] | c[6], c[4:0]};
  endfunction

  function [2:0] gainx(input [1:0] g);
    gainx = (g == 2'h3) ? 3'h1 : 3'h1 << g;
  endfunction

  function [14:0] bgx(input [7:0] c, input [7:0] t);
    bgx = {c[4], !c[4], c[1:0], !c[1], c[1:0] == 2'h2, c[1:0] == 2'h3, t};
  endfunction

  // expected read data, status word included
  function [7:0] rdx(input [7:0] b);
    if (b < 8'h05)
      rdx = m[b[2:0]];
    else if (b == 8'h05)
      rdx = {2'h0, m[2][1:0] == 2'h3, !m[2][4], m[1][7], m[0][7], r2, r1};
    else
      rdx = 8'h00;
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // one bus cycle, launched just after a rising edge
  task drive(input w, input r, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      reg_write_i <= w;
      reg_read_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
    end
  endtask

  task do_reset(input integer n);
    begin
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (i = 0; i < 5; i = i + 1)
        m[i] = 8'h00;
    end
  endtask

  // write, then read back to back, checking outputs and read data
  task wr_rd(input [7:0] a, input [7:0] d, input [7:0] b, input [2:0] c);
    begin
      drive(1'b1, 1'b0, a, d);
      adc_channel_i <= c;
      if (a < 8'h05)
        m[a[2:0]] = d & (a == 8'h02 ? 8'h13 : a == 8'h04 ? 8'h03 : 8'hff);
      drive(1'b0, 1'b1, b, 8'h00);
      #1;
      check(amp1, {ampx(m[0]), gainx(m[4][1:0]), r1});
      check(amp2, {ampx(m[1]), r2});
      check(bg, bgx(m[2], m[3]));
      drive(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check(reg_rdata_o, rdx(b));
      @(posedge clk_i);
      #1;
      check(reg_rdata_o, 8'h00);
    end
  endtask

  // status writes are ignored, so this reads every place unchanged
  task read_all;
    begin
      for (k = 0; k < 8; k = k + 1)
        wr_rd(8'h05, 8'hff, k[7:0], 3'h5);
      wr_rd(8'hff, 8'hff, 8'hff, 3'h0);
    end
  endtask

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors = num_errors + 1;
    print_verdict;
  end

  // main sequence
  initial begin
    do_reset(16);
    read_all;
    $display("reset values done");
    for (k = 0; k < 4; k = k + 1) begin
      wr_rd(8'h00, {k[1:0], 6'h2a}, 8'h00, 3'h4 + k[2:0]);
      wr_rd(8'h01, {k[1:0], 6'h35}, 8'h05, 3'h4 + k[2:0]);
      wr_rd(8'h02, 8'hfc | k[7:0], 8'h02, 3'h4 + k[2:0]);
      wr_rd(8'h04, 8'hfc | k[7:0], 8'h05, 3'h7);
    end
    wr_rd(8'h03, 8'ha5, 8'h03, 3'h6);
    $display("modes and selects done");
    for (k = 0; k < 300; k = k + 1) begin
      rnd = $random(seed);
      wr_rd({5'h00, rnd[2:0]}, rnd[15:8], {5'h00, rnd[18:16]}, rnd[22:20]);
    end
    $display("random traffic done");
    do_reset(2);
    read_all;
    $display("second reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
